// [core/anadv_top.sv]
// Auto-negotiation advertisement register with its control, status and override bits.
// Assumes a management master on a plain strobe port and a negotiation engine alongside.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns

// Overview of operation
// [R1] Link code word is built from the advertisement register while negotiation is enabled.
// [R2] Next-page bit 15 is read/write, resets to zero, advertises next-page support.
// [R3] Reserved bit 14 always reads as zero.
// [R4] Bit 14 writes take effect only while the override bit is one.
// [R5] Reserved bits 12 to 10 always read as zero.
// [R6] Writes to bits 12 to 10 and other gated bits need the override bit.
// [R7] Software writes documented defaults into every reserved bit on each write.
// [R8] Remote-fault bit 13 follows local link fault and is sent to the partner.
// [R9] Ability bits 9 to 5 advertise support when one, no support when zero.
// [R10] Bit 9 for 100Base-T4 always reads zero.
// [R11] With negotiation enabled, ability bits 8 to 5 default to one.
// [R12] Ability defaults depend on mode pin level and negotiation enable.
// [R13] Negotiation disabled: send idles, speed and duplex from control bits.
// [R14] Negotiation enabled: run negotiation advertising exactly ability bits 8 to 5.
// [R15] Status capability bits never change with the ability bits.
// [R16] Software may rewrite abilities, then request a restart to apply them.
// [R17] Selector bits reset to 00001 and are override-gated.
// [R18] Selector field sent carries 00001 for the IEEE 802.3 message type.
// [R19] Reset loads every advertisement bit with its default before any access.
module anadv_top (
    input  wire logic                        MCLK_I,
    input  wire logic                        RST_N_I,
    input  wire logic [anadv_pkg::ADDR_W-1:0] ADDR_I,
    input  wire logic [anadv_pkg::DATA_W-1:0] WDATA_I,
    input  wire logic                        WR_I,
    input  wire logic                        RD_I,
    input  wire logic                        HW_MODE_I,
    input  wire logic                        LINK_FAULT_I,
    output logic      [anadv_pkg::DATA_W-1:0] RDATA_O,
    output logic      [anadv_pkg::DATA_W-1:0] LCW_O,
    output logic                             LCW_VALID_O,
    output logic                             AN_RESTART_O,
    output logic                             SEND_IDLE_O,
    output logic                             SPEED_100_O,
    output logic                             FULL_DUPLEX_O,
    output logic      [3:0]                  AUX_RSVD_O
);

    logic                        np_reg;
    logic                        rsv14_reg;
    logic                        rf_reg;
    logic [2:0]                  rsv_reg;
    logic [3:0]                  abil_reg;
    logic [4:0]                  sel_reg;
    logic                        an_en_reg;
    logic                        rate_reg;
    logic                        duplex_reg;
    logic                        ovr_reg;
    logic                        restart_reg;
    logic [1:0]                  init_cnt_reg;
    logic [anadv_pkg::DATA_W-1:0] rdata_reg;
    logic [anadv_pkg::DATA_W-1:0] rdata_next;
    logic [anadv_pkg::DATA_W-1:0] lcw_reg;
    logic [anadv_pkg::DATA_W-1:0] adv_word;
    logic                        lcw_valid_reg;
    logic                        send_idle_reg;
    logic [3:0]                  aux_reg;
    logic                        mode_sync;
    logic                        fault_sync;
    logic                        wr_ctrl;
    logic                        wr_adv;
    logic                        wr_ovr;
    logic                        init_done;
    anadv_pkg::anadv_state_t     state_reg;
    anadv_pkg::anadv_state_t     state_next;

    // Both straps come from outside the clock domain, so each passes two stages.
    anadv_sync u_mode_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .async_i (HW_MODE_I),
        .sync_o  (mode_sync)
    );

    // The fault level changes slowly, so a few cycles of latency cost nothing.
    anadv_sync u_fault_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .async_i (LINK_FAULT_I),
        .sync_o  (fault_sync)
    );

    // Write decode.
    always_comb begin
        wr_ctrl = 1'h0;
        wr_adv  = 1'h0;
        wr_ovr  = 1'h0;
        if (WR_I && (ADDR_I == anadv_pkg::OFF_CTRL)) begin
            wr_ctrl = 1'h1;
        end else if (WR_I && (ADDR_I == anadv_pkg::OFF_ADV)) begin
            wr_adv = 1'h1;
        end else if (WR_I && (ADDR_I == anadv_pkg::OFF_OVR)) begin
            wr_ovr = 1'h1;
        end
    end

    // The strap is trusted only once both synchroniser stages have settled.
    assign init_done = (state_reg == anadv_pkg::ST_INIT)
                       && (init_cnt_reg == anadv_pkg::INIT_CYCLES);

    // Next-page bit is plain read/write with a zero reset.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            np_reg <= anadv_pkg::NP_RST; // [R19]
        end else if (wr_adv) begin
            np_reg <= WDATA_I[anadv_pkg::ADV_NP_BIT]; // [R2]
        end
    end

    // Reserved bits are kept for auxiliary use but never read back.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rsv14_reg <= anadv_pkg::RSV14_RST; // [R19]
        end else if (wr_adv && ovr_reg) begin
            rsv14_reg <= WDATA_I[anadv_pkg::ADV_RSV14_BIT]; // [R4]
        end
    end

    // A stray write could start an auxiliary function, hence the override gate.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rsv_reg <= anadv_pkg::RSV_RST; // [R19]
        end else if (wr_adv && ovr_reg) begin
            rsv_reg <= WDATA_I[anadv_pkg::ADV_RSV_HI:anadv_pkg::ADV_RSV_LO]; // [R6]
        end
    end

    // A fault level wins over a written zero; a written one lasts a single cycle.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rf_reg <= anadv_pkg::RF_RST; // [R19]
        end else begin
            rf_reg <= fault_sync | (wr_adv & WDATA_I[anadv_pkg::ADV_RF_BIT]); // [R8]
        end
    end

    // Ability defaults settle once the mode strap has passed the synchroniser.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            abil_reg <= anadv_pkg::ABIL_RST; // [R11] [R19]
        end else if (init_done) begin
            if (mode_sync && !an_en_reg) begin
                abil_reg <= anadv_pkg::ABIL_OFF; // [R12] [R13]
            end else begin
                abil_reg <= anadv_pkg::ABIL_RST; // [R12]
            end
        end else if (wr_adv) begin
            abil_reg <= WDATA_I[anadv_pkg::ADV_ABIL_HI:anadv_pkg::ADV_ABIL_LO]; // [R16]
        end
    end

    // Selector is gated by the override bit like the reserved bits.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            sel_reg <= anadv_pkg::SEL_RST; // [R17] [R19]
        end else if (wr_adv && ovr_reg) begin
            sel_reg <= WDATA_I[anadv_pkg::ADV_SEL_HI:anadv_pkg::ADV_SEL_LO]; // [R6] [R17]
        end
    end

    // Negotiation enable; clearing it sends the sequencer to idle.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            an_en_reg <= anadv_pkg::AN_EN_RST;
        end else if (wr_ctrl) begin
            an_en_reg <= WDATA_I[anadv_pkg::CTRL_AN_EN_BIT]; // [R13] [R14]
        end
    end

    // Forced speed, which only matters while negotiation is off.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rate_reg <= anadv_pkg::RATE_RST;
        end else if (wr_ctrl) begin
            rate_reg <= WDATA_I[anadv_pkg::CTRL_RATE_BIT]; // [R13]
        end
    end

    // Forced duplex, which only matters while negotiation is off.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            duplex_reg <= anadv_pkg::DUPLEX_RST;
        end else if (wr_ctrl) begin
            duplex_reg <= WDATA_I[anadv_pkg::CTRL_DUPLEX_BIT]; // [R13]
        end
    end

    // Restart is a self-clearing request, only honoured with negotiation on.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            restart_reg <= 1'h0;
        end else begin
            restart_reg <= wr_ctrl && WDATA_I[anadv_pkg::CTRL_RESTART_BIT]
                           && WDATA_I[anadv_pkg::CTRL_AN_EN_BIT]
                           && (state_reg != anadv_pkg::ST_INIT); // [R16]
        end
    end

    // Override bit opens the gated bits to software.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            ovr_reg <= anadv_pkg::OVR_RST;
        end else if (wr_ovr) begin
            ovr_reg <= WDATA_I[anadv_pkg::OVR_BIT]; // [R4] [R6]
        end
    end

    // Init counter waits out the synchroniser latency.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            init_cnt_reg <= 2'h0;
        end else if (state_reg == anadv_pkg::ST_INIT) begin
            init_cnt_reg <= init_cnt_reg + 2'h1;
        end
    end

    // Sequencer: init, then idle or negotiate as the enable bit says.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            anadv_pkg::ST_INIT: begin
                if (init_done) begin
                    if (an_en_reg) begin
                        state_next = anadv_pkg::ST_NEGOTIATE; // [R14]
                    end else begin
                        state_next = anadv_pkg::ST_IDLE; // [R13]
                    end
                end
            end
            anadv_pkg::ST_IDLE: begin
                if (an_en_reg) begin
                    state_next = anadv_pkg::ST_NEGOTIATE; // [R14]
                end
            end
            anadv_pkg::ST_NEGOTIATE: begin
                if (!an_en_reg) begin
                    state_next = anadv_pkg::ST_IDLE; // [R13]
                end
            end
            default: begin
                state_next = anadv_pkg::ST_INIT;
            end
        endcase
    end

    // State register; init is entered again on every reset.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            state_reg <= anadv_pkg::ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // The word sent to the partner carries zeros in the reserved and T4 slots.
    always_comb begin
        adv_word = 16'h0000;
        adv_word[anadv_pkg::ADV_NP_BIT] = np_reg; // [R2]
        adv_word[anadv_pkg::ADV_RSV14_BIT] = 1'h0; // [R3]
        adv_word[anadv_pkg::ADV_RF_BIT] = rf_reg; // [R8]
        adv_word[anadv_pkg::ADV_RSV_HI:anadv_pkg::ADV_RSV_LO] = 3'h0; // [R5]
        adv_word[anadv_pkg::ADV_T4_BIT] = 1'h0; // [R10]
        adv_word[anadv_pkg::ADV_ABIL_HI:anadv_pkg::ADV_ABIL_LO] = abil_reg; // [R9]
        adv_word[anadv_pkg::ADV_SEL_HI:anadv_pkg::ADV_SEL_LO] = sel_reg; // [R18]
    end

    // Link code word toward the negotiation engine, one cycle behind the register.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            lcw_reg <= 16'h0000;
        end else begin
            lcw_reg <= adv_word; // [R1] [R14]
        end
    end

    // Valid is taken from the next state so that it changes together with the state.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            lcw_valid_reg <= 1'h0;
        end else begin
            lcw_valid_reg <= (state_next == anadv_pkg::ST_NEGOTIATE); // [R1]
        end
    end

    // Idle transmission whenever negotiation is off outside init.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            send_idle_reg <= 1'h0;
        end else begin
            send_idle_reg <= (state_next == anadv_pkg::ST_IDLE); // [R13]
        end
    end

    // Reserved bits go to auxiliary logic, which is why software must keep them at default.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            aux_reg <= 4'h0;
        end else begin
            aux_reg <= {rsv14_reg, rsv_reg}; // [R7]
        end
    end

    // Read mux; unmapped indices read zero.
    always_comb begin
        rdata_next = 16'h0000;
        if (ADDR_I == anadv_pkg::OFF_CTRL) begin
            rdata_next[anadv_pkg::CTRL_RATE_BIT]   = rate_reg;
            rdata_next[anadv_pkg::CTRL_AN_EN_BIT]  = an_en_reg;
            rdata_next[anadv_pkg::CTRL_DUPLEX_BIT] = duplex_reg;
        end else if (ADDR_I == anadv_pkg::OFF_STAT) begin
            rdata_next = anadv_pkg::STAT_CAP; // [R15]
        end else if (ADDR_I == anadv_pkg::OFF_ADV) begin
            rdata_next = adv_word; // [R3] [R5] [R10]
        end else if (ADDR_I == anadv_pkg::OFF_OVR) begin
            rdata_next[anadv_pkg::OVR_BIT] = ovr_reg;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rdata_reg <= 16'h0000;
        end else if (RD_I) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    // Every output is a register, so the far side sees no decode glitches.
    assign RDATA_O       = rdata_reg;
    assign LCW_O         = lcw_reg;
    assign LCW_VALID_O   = lcw_valid_reg;
    assign AN_RESTART_O  = restart_reg;
    assign SEND_IDLE_O   = send_idle_reg;
    assign SPEED_100_O   = rate_reg; // [R13]
    assign FULL_DUPLEX_O = duplex_reg; // [R13]
    assign AUX_RSVD_O    = aux_reg;

endmodule

// [common/anadv_pkg.sv]
// Constants for the auto-negotiation advertisement register block.
// Assumes a 5-bit management register index and 16-bit register data.
package anadv_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Register indices on the management port.
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STAT = 5'h01;
    localparam logic [4:0] OFF_ADV  = 5'h04;
    localparam logic [4:0] OFF_OVR  = 5'h10;

    // Control register fields.
    localparam int CTRL_RATE_BIT    = 13;
    localparam int CTRL_AN_EN_BIT   = 12;
    localparam int CTRL_RESTART_BIT = 9;
    localparam int CTRL_DUPLEX_BIT  = 8;

    // Override register field.
    localparam int OVR_BIT = 15;

    // Advertisement register fields.
    localparam int ADV_NP_BIT    = 15;
    localparam int ADV_RSV14_BIT = 14;
    localparam int ADV_RF_BIT    = 13;
    localparam int ADV_RSV_HI    = 12;
    localparam int ADV_RSV_LO    = 10;
    localparam int ADV_T4_BIT    = 9;
    localparam int ADV_ABIL_HI   = 8;
    localparam int ADV_ABIL_LO   = 5;
    localparam int ADV_SEL_HI    = 4;
    localparam int ADV_SEL_LO    = 0;

    // Reset values.
    localparam logic       NP_RST     = 1'h0;
    localparam logic       RSV14_RST  = 1'h0;
    localparam logic       RF_RST     = 1'h0;
    localparam logic [2:0] RSV_RST    = 3'h0;
    localparam logic [3:0] ABIL_RST   = 4'hF;
    localparam logic [3:0] ABIL_OFF   = 4'h0;
    localparam logic [4:0] SEL_RST    = 5'h01;
    localparam logic       AN_EN_RST  = 1'h1;
    localparam logic       RATE_RST   = 1'h1;
    localparam logic       DUPLEX_RST = 1'h1;
    localparam logic       OVR_RST    = 1'h0;

    // Fixed capability word of the status register.
    localparam logic [15:0] STAT_CAP = 16'h7808;

    // Cycles the strap synchroniser needs before its output is trusted.
    localparam logic [1:0] INIT_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        ST_INIT,
        ST_IDLE,
        ST_NEGOTIATE
    } anadv_state_t;

endpackage

// [core/anadv_sync.sv]
// Two-stage synchroniser for one level arriving from outside the clock domain.
// Assumes the input level is held for several clock periods.
`timescale 1ns/1ns
module anadv_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      sync_o
);

    logic meta_reg;
    logic sync_reg;

    // Only the second stage is read, so no logic ever sees a metastable level.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'h0;
            sync_reg <= 1'h0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

// [tb/anadv_props.sv]
// Checker for the advertisement register block, watching only the top ports.
// Assumes one clock domain and the synchronous active-low reset of the top.
`timescale 1ns/1ns
module anadv_props (
    input wire logic        MCLK_I,
    input wire logic        RST_N_I,
    input wire logic [4:0]  ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic        HW_MODE_I,
    input wire logic        LINK_FAULT_I,
    input wire logic [15:0] RDATA_O,
    input wire logic [15:0] LCW_O,
    input wire logic        LCW_VALID_O,
    input wire logic        AN_RESTART_O,
    input wire logic        SEND_IDLE_O,
    input wire logic        SPEED_100_O,
    input wire logic        FULL_DUPLEX_O,
    input wire logic [3:0]  AUX_RSVD_O
);
    logic        ovr_q;
    logic [3:0]  aux_exp;
    logic [4:0]  sel_exp;
    logic [15:0] ctl_q;
    logic        run;
    // Init is the only time both state flags are low, so this marks a settled block.
    assign run = LCW_VALID_O | SEND_IDLE_O;
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            ovr_q <= 1'h0;
            aux_exp <= 4'h0;
            sel_exp <= 5'h01;
            ctl_q <= 16'h3100;
        end else if (WR_I) begin
            if (ADDR_I == 5'h10) ovr_q <= WDATA_I[15];
            if (ADDR_I == 5'h00) ctl_q <= WDATA_I;
            if (ADDR_I == 5'h04 && ovr_q) begin
                aux_exp <= {WDATA_I[14], WDATA_I[12:10]};
                sel_exp <= WDATA_I[4:0];
            end
        end
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    rsv_read_zero_a: assert property ((RD_I && ADDR_I == 5'h04) |=>
        (RDATA_O[14] == 1'h0 && RDATA_O[12:9] == 4'h0)) else $error("reserved bits read nonzero");
    read_idle_a: assert property (!RD_I |=> RDATA_O == 16'h0000)
        else $error("read data without a read");
    stat_fixed_a: assert property ((RD_I && ADDR_I == 5'h01) |=> RDATA_O == 16'h7808)
        else $error("status capability word changed");
    lcw_rsv_zero_a: assert property (run |-> (LCW_O[14] == 1'h0 && LCW_O[12:9] == 4'h0))
        else $error("reserved bits sent nonzero");
    lcw_follow_a: assert property ((WR_I && ADDR_I == 5'h04 && run) |=> ##1
        (LCW_O[15] == $past(WDATA_I[15], 2) && LCW_O[8:5] == $past(WDATA_I[8:5], 2)))
        else $error("code word does not follow abilities");
    gated_write_a: assert property ((WR_I && ADDR_I == 5'h04 && run) |=> ##1
        (AUX_RSVD_O == $past(aux_exp) && LCW_O[4:0] == $past(sel_exp)))
        else $error("override gating broken");
    restart_cause_a: assert property ((WR_I && ADDR_I == 5'h00 && run) |=>
        AN_RESTART_O == ($past(WDATA_I[12]) && $past(WDATA_I[9])))
        else $error("restart pulse wrong");
    restart_pulse_a: assert property (AN_RESTART_O |=> !AN_RESTART_O)
        else $error("restart longer than one cycle");
    mode_follow_a: assert property ((WR_I && ADDR_I == 5'h00 && run) |-> ##2
        (SPEED_100_O == ctl_q[13] && FULL_DUPLEX_O == ctl_q[8] && SEND_IDLE_O == !ctl_q[12]))
        else $error("mode outputs do not follow control");
    fault_sent_a: assert property (LINK_FAULT_I [*5] |-> LCW_O[13])
        else $error("local fault not sent");
    reset_value_a: assert property ($rose(RST_N_I) |-> (SPEED_100_O && FULL_DUPLEX_O &&
        AUX_RSVD_O == 4'h0 && !LCW_VALID_O)) else $error("reset values wrong");
    cover property (AN_RESTART_O);
    cover property (WR_I && ADDR_I == 5'h04 && ovr_q);
    cover property (SEND_IDLE_O);
endmodule

bind anadv_top anadv_props anadv_props_i (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .HW_MODE_I(HW_MODE_I),
    .LINK_FAULT_I(LINK_FAULT_I), .RDATA_O(RDATA_O), .LCW_O(LCW_O), .LCW_VALID_O(LCW_VALID_O),
    .AN_RESTART_O(AN_RESTART_O), .SEND_IDLE_O(SEND_IDLE_O), .SPEED_100_O(SPEED_100_O),
    .FULL_DUPLEX_O(FULL_DUPLEX_O), .AUX_RSVD_O(AUX_RSVD_O));

// [tb/anadv_sta_model.sv]
// Station manager model driving the plain register strobe port.
// Assumes the slave never stalls and read data stand one cycle after the strobe.
`timescale 1ns/1ns
module anadv_sta_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    output logic      [4:0]  addr_o,
    output logic      [15:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    initial begin
        addr_o = 5'h00;
        wdata_o = 16'h0000;
        wr_o = 1'h0;
        rd_o = 1'h0;
    end
    // Unless raw is set, reserved places carry their default zero.
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic raw);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= (a == 5'h04 && !raw) ? (d & 16'hA1FF) : d;
        wr_o <= 1'h1;
        @(posedge clk_i);
        wr_o <= 1'h0;
        // Released lines do not keep their value, so stale data cannot pass.
        addr_o <= ~a;
        wdata_o <= ~wdata_o;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'h1;
        @(posedge clk_i);
        rd_o <= 1'h0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
endmodule

// [tb/anadv_top_bench.sv]
// Self-checking bench for the advertisement register block.
// Assumes the station manager model and the bound checker beside the design.
`timescale 1ns/1ns
module anadv_top_bench;
    logic MCLK_I = 1'h0;
    logic RST_N_I = 1'h0;
    logic HW_MODE_I = 1'h0;
    logic LINK_FAULT_I = 1'h0;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, lcw;
    logic wr, rd, lcw_v, rst_p, idle, spd, fdx;
    logic [3:0] aux;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    always #5 MCLK_I = ~MCLK_I;
    anadv_top anadv_top_i (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .HW_MODE_I(HW_MODE_I), .LINK_FAULT_I(LINK_FAULT_I),
        .RDATA_O(rdata), .LCW_O(lcw), .LCW_VALID_O(lcw_v), .AN_RESTART_O(rst_p),
        .SEND_IDLE_O(idle), .SPEED_100_O(spd), .FULL_DUPLEX_O(fdx), .AUX_RSVD_O(aux));
    anadv_sta_model anadv_sta_model_i (.clk_i(MCLK_I), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    task automatic summarize();
        if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
        logic [15:0] d;
        anadv_sta_model_i.rd(a, d);
        chk(nm, e, d);
    endtask
    task automatic w(input logic [4:0] a, input logic [15:0] d, input logic raw);
        anadv_sta_model_i.wr(a, d, raw);
    endtask
    task automatic t_defaults();
        rdc("adv", 5'h04, 16'h01E1);
        rdc("ctrl", 5'h00, 16'h3100);
        w(5'h01, 16'hFFFF, 1'h1);
        rdc("status", 5'h01, 16'h7808);
        rdc("unmapped", 5'h07, 16'h0000);
        chk("lcw", 16'h01E1, lcw);
        chk("flags", 16'h0001, {14'h0000, idle, lcw_v});
    endtask
    task automatic t_abil();
        logic [15:0] d;
        for (int k = 0; k < 16; k++) begin
            d = {k[0], 6'h00, k[3:0], 5'h01};
            w(5'h04, d, 1'h0);
            rdc("adv", 5'h04, d);
            chk("lcw", d, lcw);
        end
        w(5'h04, 16'hFFFF, 1'h1);
        rdc("adv", 5'h04, 16'h81E1);
        chk("aux", 16'h0000, {12'h000, aux});
    endtask
    task automatic t_ovr();
        w(5'h10, 16'h8000, 1'h1);
        w(5'h04, 16'h5C02, 1'h1);
        rdc("adv", 5'h04, 16'h0002);
        chk("aux", 16'h000F, {12'h000, aux});
        chk("lcw", 16'h0002, lcw);
        w(5'h04, 16'h01E1, 1'h1);
        w(5'h10, 16'h0000, 1'h1);
        rdc("adv", 5'h04, 16'h01E1);
    endtask
    task automatic t_fault();
        @(posedge MCLK_I) LINK_FAULT_I <= 1'h1;
        repeat (6) @(posedge MCLK_I);
        rdc("adv", 5'h04, 16'h21E1);
        chk("lcw", 16'h21E1, lcw);
        @(posedge MCLK_I) LINK_FAULT_I <= 1'h0;
        repeat (6) @(posedge MCLK_I);
        rdc("adv", 5'h04, 16'h01E1);
    endtask
    task automatic t_ctrl(input logic [15:0] d, input logic [15:0] p, input logic [15:0] f);
        w(5'h00, d, 1'h1);
        #1;
        chk("restart", p, {15'h0000, rst_p});
        repeat (3) @(posedge MCLK_I);
        #1;
        chk("mode", f, {12'h000, idle, lcw_v, spd, fdx});
    endtask
    task automatic t_mode();
        @(posedge MCLK_I) HW_MODE_I <= 1'h1;
        RST_N_I <= 1'h0;
        repeat (3) @(posedge MCLK_I);
        RST_N_I <= 1'h1;
        repeat (8) @(posedge MCLK_I);
        rdc("adv", 5'h04, 16'h01E1);
        rdc("ctrl", 5'h00, 16'h3100);
        // Clearing the enable inside init makes the strap pick the all-off defaults.
        @(posedge MCLK_I) RST_N_I <= 1'h0;
        repeat (3) @(posedge MCLK_I);
        RST_N_I <= 1'h1;
        w(5'h00, 16'h2100, 1'h1);
        repeat (4) @(posedge MCLK_I);
        rdc("adv", 5'h04, 16'h0001);
        chk("flags", 16'h0002, {14'h0000, idle, lcw_v});
        rdc("ctrl", 5'h00, 16'h2100);
        @(posedge MCLK_I) HW_MODE_I <= 1'h0;
    endtask
    always @(posedge MCLK_I) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge MCLK_I);
        RST_N_I <= 1'h1;
        // Init holds for four edges after release; abilities reload at its end.
        repeat (6) @(posedge MCLK_I);
        t_defaults();
        t_abil();
        t_ovr();
        t_fault();
        t_ctrl(16'h1200, 16'h0001, 16'h0004);
        t_ctrl(16'h0000, 16'h0000, 16'h0008);
        t_ctrl(16'h2300, 16'h0000, 16'h000B);
        t_ctrl(16'h3100, 16'h0000, 16'h0007);
        t_mode();
        summarize();
    end
endmodule
